// File: shared/core_special_regs.svh
// indexes, reset values and field positions of the core special registers
// assumes: bus byte address is four times the index, data in byte lane 0
`ifndef CORE_SPECIAL_REGS_SVH
`define CORE_SPECIAL_REGS_SVH
`define IDX_STACK_POINTER 8'h81
`define IDX_DATA_POINTER_LOW 8'h82
`define IDX_DATA_POINTER_HIGH 8'h83
`define IDX_PROGRAM_STATUS 8'hD0
`define IDX_ARITH_PRIMARY 8'hE0
`define IDX_ARITH_SECONDARY 8'hF0
`define RST_STACK_POINTER 8'h07
`define RST_DATA_POINTER 8'h00
`define RST_PROGRAM_STATUS 8'h00
`define RST_ARITH 8'h00
`define PSW_CARRY 7
`define PSW_HALF_CARRY 6
`define PSW_USER_ZERO 5
`define PSW_BANK_HIGH 4
`define PSW_BANK_LOW 3
`define PSW_SIGNED_WRAP 2
`define PSW_USER_ONE 1
`define PSW_PARITY 0
`define BCD_DIGIT_MAX 4'h9
`define BCD_LOW_FIX 9'h006
`define BCD_HIGH_FIX 9'h060
`endif

// File: shared/core_special_pkg.sv
// types shared by the core special register block
// assumes: nothing beyond the language
package core_special_pkg;
    typedef enum logic [3:0] {
        op_none = 4'h0, op_add = 4'h1, op_addc = 4'h2, op_subb = 4'h3,
        op_product = 4'h4, op_quotient = 4'h5, op_compare_jump_unequal = 4'h6,
        op_decimal_adjust = 4'h7, op_write = 4'h8, op_bit = 4'h9,
        op_push = 4'hA, op_pop = 4'hB, op_inc_pointer = 4'hC
    } op_t;
    typedef enum logic [1:0] {bus_idle = 2'b01, bus_answer = 2'b10} bus_state_t;
    typedef struct packed {
        bus_state_t state;
        logic waitrequest;
        logic [31:0] readdata;
    } bus_regs_t;
    typedef struct packed {
        logic [7:0] arith_primary;
        logic [7:0] arith_secondary;
        logic [7:0] stack_pointer;
        logic [7:0] data_pointer_low;
        logic [7:0] data_pointer_high;
        logic [7:1] status_bits;
        logic parity;
        logic [4:0] bank_base;
        logic stack_wr;
        logic stack_rd;
        logic [7:0] stack_addr;
        logic [7:0] stack_wdata;
    } core_regs_t;
endpackage

// File: shared/core_carrier_if.sv
// carriers between the register block and its bus slave and flag unit
// assumes: all parties on one clock
`timescale 1ns/1ps
interface reg_access_if;
    logic [7:0] index;
    logic wr_stb;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic hit;
    modport bus (output index, output wr_stb, output wdata, input rdata, input hit);
    modport regs (input index, input wr_stb, input wdata, output rdata, output hit);
endinterface // reg_access_if

interface flag_alu_if;
    import core_special_pkg::*;
    op_t op;
    logic [7:0] primary;
    logic [7:0] secondary;
    logic [7:0] first;
    logic [7:0] second;
    logic carry_in;
    logic half_in;
    logic wrap_in;
    logic [7:0] result;
    logic [7:0] result_hi;
    logic carry_out;
    logic half_out;
    logic wrap_out;
    logic primary_we;
    logic secondary_we;
    modport core (output op, output primary, output secondary, output first, output second,
        output carry_in, output half_in, output wrap_in, input result, input result_hi,
        input carry_out, input half_out, input wrap_out, input primary_we, input secondary_we);
    modport alu (input op, input primary, input secondary, input first, input second,
        input carry_in, input half_in, input wrap_in, output result, output result_hi,
        output carry_out, output half_out, output wrap_out, output primary_we, output secondary_we);
endinterface // flag_alu_if

// File: verilog/flag_alu.sv
// arithmetic results and flag values for one requested operation
// assumes: purely combinational, the caller registers the outcome
`timescale 1ns/1ps
`include "core_special_regs.svh"
module flag_alu (
    flag_alu_if.alu a
);
    import core_special_pkg::*;
    logic [8:0] wide;
    logic [4:0] nib;
    logic [15:0] prod;
    logic cin;
    assign cin = (a.op == op_addc || a.op == op_subb) && a.carry_in;
    always_comb begin
        wide = 9'h000;
        nib = 5'h00;
        prod = 16'h0000;
        a.result = a.primary;
        a.result_hi = a.secondary;
        a.carry_out = a.carry_in;
        a.half_out = a.half_in;
        a.wrap_out = a.wrap_in;
        a.primary_we = 1'b0;
        a.secondary_we = 1'b0;
        unique case (a.op)
            op_add, op_addc: begin
                wide = {1'b0, a.primary} + {1'b0, a.second} + {8'h00, cin};
                nib = {1'b0, a.primary[3:0]} + {1'b0, a.second[3:0]} + {4'h0, cin};
                a.result = wide[7:0];
                a.carry_out = wide[8];
                a.half_out = nib[4];
                a.wrap_out = (a.primary[7] == a.second[7]) && (wide[7] != a.primary[7]);
                a.primary_we = 1'b1;
            end
            op_subb: begin
                wide = {1'b0, a.primary} - {1'b0, a.second} - {8'h00, cin};
                nib = {1'b0, a.primary[3:0]} - {1'b0, a.second[3:0]} - {4'h0, cin};
                a.result = wide[7:0];
                a.carry_out = wide[8];
                a.half_out = nib[4];
                a.wrap_out = (a.primary[7] != a.second[7]) && (wide[7] != a.primary[7]);
                a.primary_we = 1'b1;
            end
            op_product: begin
                prod = {8'h00, a.primary} * {8'h00, a.secondary};
                a.result = prod[7:0];
                a.result_hi = prod[15:8];
                a.carry_out = 1'b0;
                a.wrap_out = |prod[15:8];
                a.primary_we = 1'b1;
                a.secondary_we = 1'b1;
            end
            op_quotient: begin
                a.carry_out = 1'b0;
                a.wrap_out = (a.secondary == 8'h00);
                if (a.secondary != 8'h00) begin
                    a.result = a.primary / a.secondary;
                    a.result_hi = a.primary % a.secondary;
                    a.primary_we = 1'b1;
                    a.secondary_we = 1'b1;
                end
            end
            op_compare_jump_unequal: a.carry_out = (a.first < a.second);
            op_decimal_adjust: begin
                wide = {1'b0, a.primary};
                if (a.primary[3:0] > `BCD_DIGIT_MAX || a.half_in) begin
                    wide = wide + `BCD_LOW_FIX;
                end
                if (wide[7:4] > `BCD_DIGIT_MAX || a.carry_in || wide[8]) begin
                    wide = wide + `BCD_HIGH_FIX;
                end
                a.result = wide[7:0];
                a.carry_out = a.carry_in || wide[8];
                a.primary_we = 1'b1;
            end
            default: ;
        endcase
    end
endmodule // flag_alu

// File: verilog/avalon_reg_slave.sv
// avalon-mm slave with waitrequest in front of the special registers
// assumes: master holds its request until waitrequest is seen low
`timescale 1ns/1ps
module avalon_reg_slave (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // register side
    reg_access_if.bus ra
);
    import core_special_pkg::*;
    bus_regs_t q, d;
    assign ra.index = avs_address_i[9:2];
    assign ra.wdata = avs_writedata_i[7:0];
    // write lands on the edge where waitrequest is sampled low
    assign ra.wr_stb = (q.state == bus_answer) && avs_write_i && avs_byteenable_i[0];
    assign avs_readdata_o = q.readdata;
    assign avs_waitrequest_o = q.waitrequest;
    always_comb begin
        d = q;
        unique case (q.state)
            bus_idle: begin
                if (avs_read_i || avs_write_i) begin
                    d.state = bus_answer;
                    d.waitrequest = 1'b0;
                    d.readdata = ra.hit ? {24'h000000, ra.rdata} : 32'h00000000;
                end
            end
            bus_answer: begin
                d.state = bus_idle;
                d.waitrequest = 1'b1;
            end
            default: begin
                d.state = bus_idle;
                d.waitrequest = 1'b1;
            end
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '{state: bus_idle, waitrequest: 1'b1, readdata: 32'h00000000};
        end else begin
            q <= d;
        end
    end
endmodule // avalon_reg_slave

// File: verilog/core_special_registers_flags.sv
// core special registers: arithmetic pair, stack pointer, data pointer, status word
// assumes: execution logic on clk_i issues one op per cycle; software over avalon-mm
//
// Functional notes
// - primary arithmetic register, bit-addressable, reset zero
// - secondary register feeds product and quotient
// - stack pointer increments before the byte is stored
// - stack pointer resets to 07H
// - two pointer bytes form one 16-bit pointer
// - add/subtract carry from most significant bit
// - product and quotient always clear carry
// - compare-jump sets carry when first below second
// - decimal adjust sets carry past 99
// - half-carry from bit three of low nibble
// - status word layout at D0H, reset zero
// - bank bits select one of four banks
// - user flag zero untouched by hardware
`timescale 1ns/1ps
`include "core_special_regs.svh"
module core_special_registers_flags (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // avalon-mm register bus
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // requests from execution logic
    input wire core_special_pkg::op_t op_i,
    input wire logic [7:0] op_first_i,
    input wire logic [7:0] op_second_i,
    input wire logic [7:0] op_index_i,
    input wire logic [2:0] op_bit_i,
    input wire logic op_bit_value_i,
    // register views
    output logic [7:0] arith_primary_o,
    output logic [7:0] arith_secondary_o,
    output logic [7:0] stack_pointer_o,
    output logic [15:0] wide_data_pointer_o,
    output logic [7:0] program_status_o,
    output logic [4:0] bank_base_o,
    // scratch-pad stack port
    output logic stack_wr_o,
    output logic stack_rd_o,
    output logic [7:0] stack_addr_o,
    output logic [7:0] stack_wdata_o
);
    import core_special_pkg::*;

    core_regs_t q, d;
    logic [15:0] wide_ptr;
    logic [7:0] bit_byte;

    reg_access_if ra();
    flag_alu_if fa();

    function automatic logic reg_hit(input logic [7:0] idx);
        return idx inside {`IDX_STACK_POINTER, `IDX_DATA_POINTER_LOW, `IDX_DATA_POINTER_HIGH,
            `IDX_PROGRAM_STATUS, `IDX_ARITH_PRIMARY, `IDX_ARITH_SECONDARY};
    endfunction

    function automatic logic [7:0] reg_read(input core_regs_t s, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            `IDX_STACK_POINTER: v = s.stack_pointer;
            `IDX_DATA_POINTER_LOW: v = s.data_pointer_low;
            `IDX_DATA_POINTER_HIGH: v = s.data_pointer_high;
            `IDX_PROGRAM_STATUS: v = {s.status_bits, s.parity};
            `IDX_ARITH_PRIMARY: v = s.arith_primary;
            `IDX_ARITH_SECONDARY: v = s.arith_secondary;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic core_regs_t reg_write(input core_regs_t s, input logic [7:0] idx,
        input logic [7:0] v);
        core_regs_t r;
        r = s;
        case (idx)
            `IDX_STACK_POINTER: r.stack_pointer = v;
            `IDX_DATA_POINTER_LOW: r.data_pointer_low = v;
            `IDX_DATA_POINTER_HIGH: r.data_pointer_high = v;
            // parity bit is read-only
            `IDX_PROGRAM_STATUS: r.status_bits = v[7:1];
            `IDX_ARITH_PRIMARY: r.arith_primary = v;
            `IDX_ARITH_SECONDARY: r.arith_secondary = v;
            default: ;
        endcase
        return r;
    endfunction

    avalon_reg_slave u_bus (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .ra(ra.bus)
    );

    flag_alu u_alu (
        .a(fa.alu)
    );

    assign ra.rdata = reg_read(q, ra.index);
    assign ra.hit = reg_hit(ra.index);

    assign fa.op = op_i;
    assign fa.primary = q.arith_primary;
    assign fa.secondary = q.arith_secondary;
    assign fa.first = op_first_i;
    assign fa.second = op_second_i;
    assign fa.carry_in = q.status_bits[`PSW_CARRY];
    assign fa.half_in = q.status_bits[`PSW_HALF_CARRY];
    assign fa.wrap_in = q.status_bits[`PSW_SIGNED_WRAP];

    always_comb begin
        d = q;
        d.stack_wr = 1'b0;
        d.stack_rd = 1'b0;
        wide_ptr = {q.data_pointer_high, q.data_pointer_low} + 16'h0001;
        bit_byte = reg_read(q, op_index_i);
        unique case (op_i)
            op_none: ;
            op_add, op_addc, op_subb, op_product, op_quotient, op_compare_jump_unequal,
            op_decimal_adjust: begin
                if (fa.primary_we) begin
                    d.arith_primary = fa.result;
                end
                if (fa.secondary_we) begin
                    d.arith_secondary = fa.result_hi;
                end
                // user flags and bank bits are never touched here
                d.status_bits[`PSW_CARRY] = fa.carry_out;
                d.status_bits[`PSW_HALF_CARRY] = fa.half_out;
                d.status_bits[`PSW_SIGNED_WRAP] = fa.wrap_out;
            end
            op_write: d = reg_write(d, op_index_i, op_second_i);
            op_bit: begin
                // bit access is read-modify-write of one byte
                bit_byte[op_bit_i] = op_bit_value_i;
                d = reg_write(d, op_index_i, bit_byte);
            end
            op_push: begin
                d.stack_pointer = q.stack_pointer + 8'h01;
                d.stack_addr = q.stack_pointer + 8'h01;
                d.stack_wdata = op_second_i;
                d.stack_wr = 1'b1;
            end
            op_pop: begin
                d.stack_addr = q.stack_pointer;
                d.stack_rd = 1'b1;
                d.stack_pointer = q.stack_pointer - 8'h01;
            end
            op_inc_pointer: begin
                d.data_pointer_high = wide_ptr[15:8];
                d.data_pointer_low = wide_ptr[7:0];
            end
            default: ;
        endcase
        // software write wins over the core in the same cycle
        if (ra.wr_stb) begin
            d = reg_write(d, ra.index, ra.wdata);
        end
        d.parity = ^d.arith_primary;
        d.bank_base = {d.status_bits[`PSW_BANK_HIGH], d.status_bits[`PSW_BANK_LOW], 3'b000};
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '{
                arith_primary: `RST_ARITH,
                arith_secondary: `RST_ARITH,
                stack_pointer: `RST_STACK_POINTER,
                data_pointer_low: `RST_DATA_POINTER,
                data_pointer_high: `RST_DATA_POINTER,
                status_bits: 7'(`RST_PROGRAM_STATUS >> 1),
                parity: 1'b0,
                bank_base: 5'h00,
                stack_wr: 1'b0,
                stack_rd: 1'b0,
                stack_addr: 8'h00,
                stack_wdata: 8'h00
            };
        end else begin
            q <= d;
        end
    end

    assign arith_primary_o = q.arith_primary;
    assign arith_secondary_o = q.arith_secondary;
    assign stack_pointer_o = q.stack_pointer;
    assign wide_data_pointer_o = {q.data_pointer_high, q.data_pointer_low};
    assign program_status_o = {q.status_bits, q.parity};
    assign bank_base_o = q.bank_base;
    assign stack_wr_o = q.stack_wr;
    assign stack_rd_o = q.stack_rd;
    assign stack_addr_o = q.stack_addr;
    assign stack_wdata_o = q.stack_wdata;
endmodule // core_special_registers_flags

// File: bench/core_special_assertions.sv
// checker for the core special registers: bus handshake and flag relations
// assumes: bound to the top module, single clock, synchronous reset
`timescale 1ns/1ps
module core_special_assertions
    import core_special_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire core_special_pkg::op_t op_i,
    input wire logic [7:0] op_first_i,
    input wire logic [7:0] op_second_i,
    input wire logic [7:0] arith_primary_o,
    input wire logic [7:0] stack_pointer_o,
    input wire logic [15:0] wide_data_pointer_o,
    input wire logic [7:0] program_status_o,
    input wire logic [4:0] bank_base_o,
    input wire logic stack_wr_o,
    input wire logic [7:0] stack_addr_o,
    input wire logic [7:0] stack_wdata_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic bw;
    logic [8:0] sum_q;
    logic [4:0] nib_q;
    assign bw = avs_write_i && !avs_waitrequest_o;
    // operand sums seen one edge later
    always_ff @(posedge clk_i) begin
        sum_q <= {1'b0, arith_primary_o} + {1'b0, op_second_i};
        nib_q <= {1'b0, arith_primary_o[3:0]} + {1'b0, op_second_i[3:0]};
    end
    sequence bus_take;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence bus_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    bus_wait_a: assert property (bus_take |=> bus_answer)
        else $error("bus answer late or held too long");
    reset_vals_a: assert property ($rose(rst_n_i) |-> stack_pointer_o == 8'h07 && arith_primary_o == 8'h00
        && wide_data_pointer_o == 16'h0000 && program_status_o == 8'h00) else $error("reset value wrong");
    push_order_a: assert property (op_i == op_push && !bw |=> stack_wr_o
        && stack_addr_o == $past(stack_pointer_o) + 8'h01 && stack_pointer_o == stack_addr_o
        && stack_wdata_o == $past(op_second_i)) else $error("push not pre-incremented");
    add_flags_a: assert property (op_i == op_add && !bw |=> program_status_o[7:6] == {sum_q[8], nib_q[4]})
        else $error("add carry or half-carry wrong");
    muldiv_carry_a: assert property (op_i inside {op_product, op_quotient} && !bw |=> !program_status_o[7])
        else $error("carry left set after product or quotient");
    cmp_carry_a: assert property (op_i == op_compare_jump_unequal && !bw
        |=> program_status_o[7] == ($past(op_first_i) < $past(op_second_i))) else $error("compare carry wrong");
    parity_even_a: assert property (^{arith_primary_o, program_status_o[0]} == 1'b0)
        else $error("parity bit not even");
    bank_base_a: assert property (bank_base_o == {program_status_o[4:3], 3'b000})
        else $error("bank base does not follow bank bits");
    user_zero_a: assert property (!bw && op_i != op_write && op_i != op_bit
        |=> $stable(program_status_o[5])) else $error("user flag zero changed by hardware");
    ptr_inc_a: assert property (op_i == op_inc_pointer && !bw
        |=> wide_data_pointer_o == $past(wide_data_pointer_o) + 16'h0001) else $error("wide pointer step wrong");
endmodule // core_special_assertions

bind core_special_registers_flags core_special_assertions i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .op_i(op_i),
    .op_first_i(op_first_i), .op_second_i(op_second_i), .arith_primary_o(arith_primary_o),
    .stack_pointer_o(stack_pointer_o), .wide_data_pointer_o(wide_data_pointer_o),
    .program_status_o(program_status_o), .bank_base_o(bank_base_o), .stack_wr_o(stack_wr_o),
    .stack_addr_o(stack_addr_o), .stack_wdata_o(stack_wdata_o));

// File: bench/exec_partner.sv
// execution-side model: issues one op per clock to the register block
// assumes: tasks are entered just after a rising edge
`timescale 1ns/1ps
module exec_partner
    import core_special_pkg::*;
(
    input wire logic clk_i,
    output core_special_pkg::op_t op_o,
    output logic [7:0] first_o,
    output logic [7:0] second_o,
    output logic [7:0] index_o,
    output logic [2:0] bit_o,
    output logic bit_value_o
);
    initial begin
        op_o = op_none;
        first_o = 8'h5A;
        second_o = 8'hA5;
        index_o = 8'h3C;
        bit_o = 3'h0;
        bit_value_o = 1'b0;
    end
    task automatic issue(input op_t o, input logic [7:0] f, input logic [7:0] s, input logic [7:0] idx,
        input logic [2:0] b, input logic v);
        op_o <= o;
        first_o <= f;
        second_o <= s;
        index_o <= idx;
        bit_o <= b;
        bit_value_o <= v;
        @(posedge clk_i);
    endtask
    // idle operands except the bit value keep toggling
    task automatic idle;
        op_o <= op_none;
        first_o <= ~first_o;
        second_o <= ~second_o;
        index_o <= ~index_o;
        bit_o <= ~bit_o;
        @(posedge clk_i);
    endtask
endmodule // exec_partner

// File: bench/core_special_registers_flags_tb.sv
// self-checking bench for the core special registers
// assumes: exec_partner issues ops, bench drives avalon-mm
`timescale 1ns/1ps
`include "core_special_regs.svh"
module core_special_registers_flags_tb;
    import core_special_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [9:0] avs_address_i = 10'h000;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'h1;
    logic [31:0] avs_readdata_o, rd;
    logic avs_waitrequest_o, bitv, stack_wr_o, stack_rd_o;
    op_t op;
    logic [7:0] first, second, index, arith_primary_o, arith_secondary_o, stack_pointer_o, program_status_o;
    logic [7:0] stack_addr_o, stack_wdata_o;
    logic [2:0] bitn;
    logic [15:0] wide_data_pointer_o;
    logic [4:0] bank_base_o;
    integer seed = 49824;
    int acc, bb, sp, dp, program_status, fails, checks_done, t, u, i;
    logic [7:0] ridx [7] = '{`IDX_STACK_POINTER, `IDX_DATA_POINTER_LOW, `IDX_DATA_POINTER_HIGH,
        `IDX_PROGRAM_STATUS, `IDX_ARITH_PRIMARY, `IDX_ARITH_SECONDARY, 8'h90};
    int rv [7] = '{7, 0, 0, 0, 0, 0, 0};
    op_t ops [7] = '{op_add, op_addc, op_subb, op_product, op_quotient, op_compare_jump_unequal, op_write};
    always #25 clk_i = ~clk_i;
    core_special_registers_flags i_dut (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .op_i(op), .op_first_i(first),
        .op_second_i(second), .op_index_i(index), .op_bit_i(bitn), .op_bit_value_i(bitv), .arith_primary_o,
        .arith_secondary_o, .stack_pointer_o, .wide_data_pointer_o, .program_status_o, .bank_base_o,
        .stack_wr_o, .stack_rd_o, .stack_addr_o, .stack_wdata_o);
    exec_partner i_exec (.clk_i, .op_o(op), .first_o(first), .second_o(second), .index_o(index), .bit_o(bitn),
        .bit_value_o(bitv));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
        int n;
        logic [31:0] r;
        r = $random(seed);
        n = 0;
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= {r[31:8], d};
        avs_byteenable_i <= be;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        rd = avs_readdata_o;
        if (avs_waitrequest_o !== 1'b0) begin
            fails++;
            print_verdict();
        end
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic check_all;
        check(arith_primary_o, acc[7:0]);
        check(arith_secondary_o, bb[7:0]);
        check(stack_pointer_o, sp[7:0]);
        check(wide_data_pointer_o, dp[15:0]);
        check(program_status_o & 8'hFB, (program_status & 8'hFA) | (^acc[7:0]));
        check(bank_base_o, program_status[4:3] * 8);
    endtask
    task automatic run(input op_t o, input int f, input int s);
        int r, c;
        c = (o == op_add) ? 0 : program_status[7];
        case (o)
            op_add, op_addc: begin
                program_status[6] = (acc % 16) + (s % 16) + c > 15;
                r = acc + s + c;
                program_status[7] = r > 255;
                acc = r % 256;
            end
            op_subb: begin
                program_status[6] = (acc % 16) < (s % 16) + c;
                program_status[7] = acc < s + c;
                acc = (acc - s - c + 256) % 256;
            end
            op_product: begin
                r = acc * bb;
                acc = r % 256;
                bb = r / 256;
                program_status[7] = 0;
            end
            op_quotient: begin
                r = acc / bb;
                bb = acc % bb;
                acc = r;
                program_status[7] = 0;
            end
            op_compare_jump_unequal: program_status[7] = f < s;
            op_decimal_adjust: begin
                acc = f % 100 / 10 * 16 + f % 10;
                program_status[7] = program_status[7] | (f > 99);
            end
            op_write: acc = s;
            op_push: sp = (sp + 1) % 256;
            op_pop: sp = (sp + 255) % 256;
            op_inc_pointer: dp = (dp + 1) % 65536;
            default: ;
        endcase
        i_exec.issue(o, f[7:0], s[7:0], `IDX_ARITH_PRIMARY, 3'h0, 1'b0);
        i_exec.idle();
        if (o == op_push) check({stack_wr_o, stack_addr_o, stack_wdata_o}, {1'b1, sp[7:0], s[7:0]});
        if (o == op_pop) check({stack_rd_o, stack_addr_o}, {1'b1, 8'(sp + 1)});
        check_all();
    endtask
    initial begin
        {acc, bb, dp, program_status, fails, checks_done} = '0;
        sp = 7;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (i = 0; i < 7; i++) begin
            bus(1'b0, ridx[i], 8'h00, 4'h1);
            check(rd, rv[i]);
        end
        run(op_push, 0, $random(seed) & 255);
        check(stack_addr_o, 8'h08);
        sp = sp + 2;
        i_exec.issue(op_push, 8'h00, 8'h11, 8'h00, 3'h0, 1'b0);
        i_exec.issue(op_push, 8'h00, 8'h22, 8'h00, 3'h0, 1'b0);
        i_exec.idle();
        check({stack_addr_o, stack_wdata_o}, 16'h0A22);
        run(op_pop, 0, 0);
        bus(1'b1, `IDX_STACK_POINTER, 8'hEE, 4'h0);
        bus(1'b0, `IDX_STACK_POINTER, 8'h00, 4'h1);
        check(rd, sp);
        for (i = 0; i < 6; i++) begin
            t = $random(seed) & 255;
            bus(1'b1, ridx[i], t[7:0], 4'h1);
            case (i)
                0: sp = t;
                1: dp = dp / 256 * 256 + t;
                2: dp = t * 256 + dp % 256;
                3: program_status = t;
                4: acc = t;
                default: bb = t;
            endcase
            check_all();
        end
        for (i = 0; i < 4; i++) begin
            program_status = i * 8 + 32;
            bus(1'b1, `IDX_PROGRAM_STATUS, program_status[7:0], 4'h1);
            check_all();
        end
        dp = 255;
        bus(1'b1, `IDX_DATA_POINTER_LOW, 8'hFF, 4'h1);
        bus(1'b1, `IDX_DATA_POINTER_HIGH, 8'h00, 4'h1);
        run(op_inc_pointer, 0, 0);
        for (i = 0; i < 60; i++) begin
            t = ($random(seed) & 32'h7FFF) % 7;
            run((ops[t] == op_quotient && bb == 0) ? op_add : ops[t], $random(seed) & 255, $random(seed) & 255);
        end
        for (i = 0; i < 12; i++) begin
            t = ($random(seed) & 32'h7FFF) % 100;
            u = ($random(seed) & 32'h7FFF) % 100;
            run(op_write, 0, t / 10 * 16 + t % 10);
            run(op_add, 0, u / 10 * 16 + u % 10);
            run(op_decimal_adjust, t + u, 0);
            check(program_status_o[7], t + u > 99);
        end
        acc[6] = !acc[6];
        i_exec.issue(op_bit, 8'h00, 8'h00, `IDX_ARITH_PRIMARY, 3'h6, acc[6]);
        program_status[5] = 0;
        i_exec.issue(op_bit, 8'h00, 8'h00, `IDX_PROGRAM_STATUS, 3'h5, 1'b0);
        i_exec.idle();
        check_all();
        print_verdict();
    end
endmodule // core_special_registers_flags_tb
